// ---- cop_watchdog_timer.sv ----
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cop_watchdog_timer
   import watchdog_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        system_reset,
   input  wire logic        stop_mode,
   input  wire logic        debug_mode,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             watchdog_reset
);
   localparam int TW = $clog2(TICK_CYCLES_P);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES_P - 1);

   function automatic logic [CNT_W-1:0] terminal(input wd_cfg_t c);
      logic [CNT_W:0] one;
      int             e;
      one = '0;
      one[0] = 1'b1;
      if (c.watchdog_clock_select) begin
         e = c.watchdog_timeout_select ? EXP_FAST_LONG : EXP_FAST_SHORT;
      end else begin
         e = c.watchdog_timeout_select ? EXP_SLOW_LONG : EXP_SLOW_SHORT;
      end
      terminal = CNT_W'((one << e) - 1'b1);
   endfunction : terminal

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   addr_phase_t      ap;
   addr_phase_t      next_ap;
   logic [31:0]      next_hrdata;
   wd_cfg_t          cfg;
   wd_cfg_t          next_cfg;
   logic             lock1;
   logic             lock2;
   logic             next_lock1;
   logic             next_lock2;
   logic             wd_flag;
   logic             next_wd_flag;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic [TW-1:0]    prescale;
   logic [TW-1:0]    next_prescale;
   logic             tick;
   logic             next_tick;
   logic             next_wd_reset;
   logic             sys_clear;
   logic             wr_opt1;
   logic             wr_opt2;
   logic             service;
   logic             advance;
   logic             overflow;
   logic             take;

   assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

   always_comb begin
      next_ap.wr  = take && hwrite;
      next_ap.ofs = haddr[7:0] & 8'hfc;
      next_hrdata = '0;
      if (take && !hwrite) begin
         case (haddr[7:0] & 8'hfc)
            OFS_OPT1: begin
               next_hrdata[ENABLE_BIT] = next_cfg.watchdog_enable;
               next_hrdata[TSEL_BIT]   = next_cfg.watchdog_timeout_select;
            end
            OFS_OPT2: begin
               next_hrdata[CSEL_BIT] = next_cfg.watchdog_clock_select;
            end
            OFS_SRS: begin
               next_hrdata[WD_SRC_BIT] = next_wd_flag;
            end
            OFS_COUNT: begin
               next_hrdata[CNT_W-1:0] = next_count;
            end
            default: begin
               next_hrdata = '0;
            end
         endcase
      end
   end

   // Zero wait states: read data is fetched in the address phase, so it
   // is taken from the next values to see a write still in its data phase.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ap        <= '0;
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         ap        <= next_ap;
         hrdata    <= next_hrdata;
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

   // ------------------------------------------------------------
   // Write-once options and reset source
   // ------------------------------------------------------------
   assign sys_clear = system_reset || watchdog_reset;
   assign wr_opt1   = ap.wr && (ap.ofs == OFS_OPT1) && !lock1;
   assign wr_opt2   = ap.wr && (ap.ofs == OFS_OPT2) && !lock2;
   assign service   = ap.wr && (ap.ofs == OFS_SRS);

   always_comb begin
      next_cfg   = cfg;
      next_lock1 = lock1;
      next_lock2 = lock2;
      next_wd_flag = wd_flag;
      if (sys_clear) begin
         next_cfg   = CFG_RST; // R1 R7
         next_lock1 = 1'b0;
         next_lock2 = 1'b0;
      end else begin
         if (wr_opt1) begin
            next_cfg.watchdog_enable         = hwdata[ENABLE_BIT];
            next_cfg.watchdog_timeout_select = hwdata[TSEL_BIT];
            next_lock1 = 1'b1; // R9
         end
         if (wr_opt2) begin
            next_cfg.watchdog_clock_select = hwdata[CSEL_BIT];
            next_lock2 = 1'b1; // R9
         end
      end
      // A watchdog reset wins over another source in the same cycle
      if (watchdog_reset) begin
         next_wd_flag = 1'b1; // R16
      end else if (system_reset) begin
         next_wd_flag = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg     <= CFG_RST;
         lock1   <= 1'b0;
         lock2   <= 1'b0;
         wd_flag <= 1'b0;
      end else begin
         cfg     <= next_cfg;
         lock1   <= next_lock1;
         lock2   <= next_lock2;
         wd_flag <= next_wd_flag;
      end
   end

   // ------------------------------------------------------------
   // Tick divider and counter
   // ------------------------------------------------------------
   // The tick stands in for a free-running low-power oscillator, so it
   // keeps running in stop and debug; only the counter reacts to them.
   always_comb begin
      next_tick     = (prescale == TICK_LAST);
      next_prescale = next_tick ? '0 : prescale + 1'b1;
   end

   always_comb begin
      advance = cfg.watchdog_enable && !debug_mode && // R2 R13
                (cfg.watchdog_clock_select ? !stop_mode : tick); // R4 R14
      overflow = 1'b0;
      next_count = count;
      if (sys_clear || service || wr_opt1 || wr_opt2) begin
         next_count = '0; // R3 R11 R17
      end else if (!cfg.watchdog_clock_select && stop_mode) begin
         next_count = '0; // R15
      end else if (advance) begin
         if (count == terminal(cfg)) begin // R5 R6
            overflow   = 1'b1;
            next_count = '0;
         end else begin
            next_count = count + 1'b1;
         end
      end
      next_wd_reset = overflow; // R8
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prescale       <= '0;
         tick           <= 1'b0;
         count          <= '0;
         watchdog_reset <= 1'b0;
      end else begin
         prescale       <= next_prescale;
         tick           <= next_tick;
         count          <= next_count;
         watchdog_reset <= next_wd_reset;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic clr_any;
   assign clr_any = sys_clear || service || wr_opt1 || wr_opt2;

   property p_service;
      @(posedge clk) disable iff (rst)
      service && !sys_clear |=> (count == '0) && $stable(wd_flag);
   endproperty
   a_service: assert property (p_service) // R3
      else $error("service write did not clear counter");

   property p_disabled;
      @(posedge clk) disable iff (rst)
      !cfg.watchdog_enable && !sys_clear |=> !watchdog_reset;
   endproperty
   a_disabled: assert property (p_disabled) // R2
      else $error("disabled watchdog raised a reset");

   property p_slow_idle;
      @(posedge clk) disable iff (rst)
      !cfg.watchdog_clock_select && !tick && !stop_mode && !clr_any
      |=> $stable(count);
   endproperty
   a_slow_idle: assert property (p_slow_idle) // R4
      else $error("slow counter moved without a tick");

   property p_slow_short;
      @(posedge clk) disable iff (rst)
      cfg == 3'b100 && count == 18'h0001f && advance && !clr_any
      && !stop_mode |=> watchdog_reset;
   endproperty
   a_slow_short: assert property (p_slow_short) // R5
      else $error("short slow timeout not at 32 counts");

   property p_slow_long;
      @(posedge clk) disable iff (rst)
      cfg == 3'b110 && count == 18'h000ff && advance && !clr_any
      && !stop_mode |=> watchdog_reset;
   endproperty
   a_slow_long: assert property (p_slow_long) // R5 R8
      else $error("long slow timeout not at 256 counts");

   property p_sys_reset;
      @(posedge clk) disable iff (rst)
      system_reset |=> count == '0 && cfg == CFG_RST && !lock1 && !lock2;
   endproperty
   a_sys_reset: assert property (p_sys_reset) // R1 R17
      else $error("system reset did not restore defaults");

   property p_fast_short;
      @(posedge clk) disable iff (rst)
      cfg == 3'b101 && count == 18'h01fff && advance && !clr_any
      |=> watchdog_reset ##1 (count == '0);
   endproperty
   a_fast_short: assert property (p_fast_short) // R6 R8
      else $error("short bus timeout not at 2^13");

   property p_wd_reset;
      @(posedge clk) disable iff (rst)
      watchdog_reset |=> wd_flag && cfg == CFG_RST && count == '0
      && !lock1 && !lock2;
   endproperty
   a_wd_reset: assert property (p_wd_reset) // R1 R7 R16 R17
      else $error("watchdog reset did not restore defaults");

   property p_lock;
      @(posedge clk) disable iff (rst)
      lock1 && lock2 && !sys_clear |=> $stable(cfg);
   endproperty
   a_lock: assert property (p_lock) // R9
      else $error("locked options changed");

   property p_first_write;
      @(posedge clk) disable iff (rst)
      wr_opt1 || wr_opt2 |=> count == '0;
   endproperty
   a_first_write: assert property (p_first_write) // R11
      else $error("option write did not clear counter");

   property p_debug;
      @(posedge clk) disable iff (rst)
      debug_mode && !clr_any && !(stop_mode && !cfg.watchdog_clock_select)
      |=> $stable(count);
   endproperty
   a_debug: assert property (p_debug) // R13
      else $error("counter moved in debug mode");

   property p_stop_fast;
      @(posedge clk) disable iff (rst)
      cfg.watchdog_clock_select && stop_mode && !clr_any |=> $stable(count);
   endproperty
   a_stop_fast: assert property (p_stop_fast) // R14
      else $error("bus clock counter moved in stop");

   property p_stop_slow;
      @(posedge clk) disable iff (rst)
      !cfg.watchdog_clock_select && stop_mode |=> count == '0;
   endproperty
   a_stop_slow: assert property (p_stop_slow) // R15
      else $error("slow counter not zero in stop");

endmodule : cop_watchdog_timer
`default_nettype wire

// ---- watchdog_pkg.sv ----
//
// Notes on behaviour
// R1 - Any reset sets the watchdog enable bit, so the watchdog runs by default.
// R2 - With the enable bit cleared the watchdog never causes a reset.
// R3 - Any write to the reset status address clears the counter, data unchanged.
// R4 - Clock select zero counts the 1 kHz tick, one counts the bus clock.
// R5 - On the 1 kHz tick, timeout select gives 32 or 256 counts.
// R6 - On the bus clock, timeout select gives 2^13 or 2^18 cycles.
// R7 - After reset: 1 kHz tick and the long timeout.
// R8 - Reaching the overflow count while enabled raises a system reset.
// R9 - Each option register takes one write after reset, later writes ignored.
// R10 - Software writes both option registers at start-up to lock them.
// R11 - The first write to either option register clears the counter.
// R12 - Software services the watchdog from the main loop, not an interrupt.
// R13 - The counter holds while in background debug mode; on the 1 kHz source, stop during debug still zeroes it.
// R14 - Bus clock source: counter freezes in stop and resumes afterwards.
// R15 - 1 kHz source: counter is zeroed in stop and restarts from zero.
// R16 - A watchdog reset sets its own bit in the reset status register.
// R17 - Every system reset, the watchdog's own included, clears the counter.
package watchdog_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ        = 125;
   localparam int TICK_PERIOD_US = 1000;
   localparam int TICK_CYCLES    = TICK_PERIOD_US * CLK_MHZ;
   localparam int CNT_W          = 18;
   localparam int EXP_SLOW_SHORT = 5;
   localparam int EXP_SLOW_LONG  = 8;
   localparam int EXP_FAST_SHORT = 13;
   localparam int EXP_FAST_LONG  = 18;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_OPT1  = 8'h00;
   localparam logic [7:0] OFS_OPT2  = 8'h04;
   localparam logic [7:0] OFS_SRS   = 8'h08;
   localparam logic [7:0] OFS_COUNT = 8'h0c;
   localparam int ENABLE_BIT  = 7;
   localparam int TSEL_BIT    = 6;
   localparam int CSEL_BIT    = 7;
   localparam int WD_SRC_BIT  = 5;
   localparam logic ENABLE_RST = 1'b1;
   localparam logic TSEL_RST   = 1'b1;
   localparam logic CSEL_RST   = 1'b0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef struct packed {
      logic watchdog_enable;
      logic watchdog_timeout_select;
      logic watchdog_clock_select;
   } wd_cfg_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] ofs;
   } addr_phase_t;

   localparam wd_cfg_t CFG_RST = '{ENABLE_RST, TSEL_RST, CSEL_RST};
endpackage : watchdog_pkg

// ---- test_cop_watchdog_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_cop_watchdog_timer;
   import watchdog_pkg::*;
   // ---------------------------------------------------
   // Bench signals
   // ---------------------------------------------------
   localparam int TICK = 4;
   logic        clk, rst, system_reset, stop_mode, debug_mode;
   logic        hsel, hwrite, hreadyout, hresp, watchdog_reset;
   logic [31:0] haddr, hwdata, hrdata, v, w;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          n_mismatch, compares, n_wd;

   cop_watchdog_timer #(.TICK_CYCLES_P(TICK)) DUT (
      .clk(clk), .rst(rst), .system_reset(system_reset),
      .stop_mode(stop_mode), .debug_mode(debug_mode), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .watchdog_reset(watchdog_reset));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Counted here so a one-cycle pulse is never missed between reads
   always @(posedge clk) begin
      if (watchdog_reset === 1'b1) n_wd++;
   end

   // ---------------------------------------------------
   // Tasks
   // ---------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic bus_addr(input logic [7:0] a, input logic wr);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
   endtask : bus_addr

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      bus_addr(a, 1'b1);
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      bus_addr(a, 1'b0);
      do @(posedge clk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask : bus_rd

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
      bus_rd(a, v);
      chk(nm, e, v);
   endtask : rd_chk

   // Pulse count after a wait: first just before the overflow, then after
   task automatic pulses(input int lo, input int hi, input int base);
      repeat (lo) @(posedge clk);
      chk("pulses early", base, n_wd);
      repeat (hi - lo) @(posedge clk);
      chk("pulses late", base + 1, n_wd);
   endtask : pulses

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   // ---------------------------------------------------
   // Tests
   // ---------------------------------------------------
   initial begin
      {rst, system_reset, stop_mode, debug_mode, hsel, hwrite} = 6'h21;
      {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
      n_mismatch = 0;
      compares = 0;
      n_wd = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk("opt1 reset", OFS_OPT1, 32'h000000c0);
      rd_chk("opt2 reset", OFS_OPT2, 32'h00000000);
      rd_chk("status reset", OFS_SRS, 32'h00000000);
      rd_chk("unmapped", 8'h10, 32'h00000000);
      $display("test defaults done");
      // Stop zeroes the slow count; overflow is timed from the exit
      stop_mode <= 1'b1;
      repeat (20) @(posedge clk);
      rd_chk("count in stop", OFS_COUNT, 32'h00000000);
      stop_mode <= 1'b0;
      pulses(250 * TICK, 262 * TICK, 0);
      rd_chk("wd source", OFS_SRS, 32'h00000020);
      // The count restarts at the pulse, so only a few ticks have passed
      bus_rd(OFS_COUNT, v);
      chk("count after", 1, {31'h0, v < 10});
      $display("test slow long done");
      bus_wr(OFS_OPT1, 32'h00000080);
      bus_wr(OFS_OPT2, 32'h00000000);
      pulses(30 * TICK, 34 * TICK, 1);
      $display("test slow short done");
      bus_wr(OFS_OPT2, 32'h00000080);
      bus_wr(OFS_OPT1, 32'h00000080);
      bus_wr(OFS_OPT1, 32'h000000c0);
      bus_wr(OFS_OPT2, 32'h00000000);
      rd_chk("opt1 locked", OFS_OPT1, 32'h00000080);
      rd_chk("opt2 locked", OFS_OPT2, 32'h00000080);
      debug_mode <= 1'b1;
      bus_rd(OFS_COUNT, w);
      repeat (30) @(posedge clk);
      rd_chk("count debug", OFS_COUNT, w);
      debug_mode <= 1'b0;
      stop_mode <= 1'b1;
      bus_rd(OFS_COUNT, w);
      repeat (30) @(posedge clk);
      rd_chk("count stop", OFS_COUNT, w);
      stop_mode <= 1'b0;
      repeat (3) @(posedge clk);
      bus_rd(OFS_COUNT, v);
      chk("count resumes", 1, {31'h0, v > w && v < w + 12});
      bus_wr(OFS_SRS, 32'hffffffff);
      bus_rd(OFS_COUNT, v);
      chk("serviced", 1, {31'h0, v < 8});
      rd_chk("status kept", OFS_SRS, 32'h00000020);
      pulses(8150, 8250, 2);
      $display("test bus short done");
      // Debug holds the count, so the clear by the reset is seen exactly
      debug_mode   <= 1'b1;
      system_reset <= 1'b1;
      @(posedge clk);
      system_reset <= 1'b0;
      rd_chk("opt1 sysrst", OFS_OPT1, 32'h000000c0);
      rd_chk("status sysrst", OFS_SRS, 32'h00000000);
      rd_chk("count sysrst", OFS_COUNT, 32'h00000000);
      debug_mode <= 1'b0;
      bus_wr(OFS_OPT1, 32'h00000040);
      // Longer than the default long timeout, yet no pulse may come
      repeat (1100) @(posedge clk);
      chk("pulses disabled", 3, n_wd);
      rd_chk("count disabled", OFS_COUNT, 32'h00000000);
      $display("test disable and reset done");
      close_out();
   end

   // Tests need some 10700 cycles; this cuts a hang well past that
   initial begin
      repeat (50000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
endmodule : test_cop_watchdog_timer
`default_nettype wire
